// *** shared/mbt_pkg.sv ***
package mbt_pkg;

	// ************************************************************
	// Instruction cycle timing
	// ************************************************************
	localparam int unsigned SYS_CLK_PER_ICYCLE = 4;
	localparam logic [1:0] PHASE_LAST = 2'(SYS_CLK_PER_ICYCLE - 1);

	// ************************************************************
	// Register byte offsets and memory window bit
	// ************************************************************
	localparam logic [8:0] OFS_INSTR = 9'h000;
	localparam logic [8:0] OFS_WORK = 9'h004;
	localparam logic [8:0] OFS_STATUS = 9'h008;
	localparam logic [8:0] OFS_PC = 9'h00c;
	localparam logic [8:0] OFS_CYC_LAST = 9'h010;
	localparam logic [8:0] OFS_CYC_TOTAL = 9'h014;
	localparam int unsigned MEM_WIN_BIT = 8;

	// ************************************************************
	// Instruction word fields
	// ************************************************************
	localparam int unsigned F_OP_LSB = 0;
	localparam int unsigned F_IMM_SEL = 5;
	localparam int unsigned F_TO_MEM = 6;
	localparam int unsigned F_BIT_LSB = 7;
	localparam int unsigned F_ADDR_LSB = 10;
	localparam int unsigned F_TARGET_LSB = 16;
	localparam int unsigned F_IMM_LSB = 24;

	// ************************************************************
	// Status bit positions
	// ************************************************************
	localparam int unsigned FLG_C = 0;
	localparam int unsigned FLG_HC = 1;
	localparam int unsigned FLG_Z = 2;
	localparam int unsigned FLG_OVF = 3;
	localparam int unsigned FLG_SGN = 4;
	localparam int unsigned FLG_CHZ = 5;
	localparam int unsigned STS_BUSY = 8;
	localparam int unsigned STS_SKIP = 9;

	// ************************************************************
	// Reset values, PCL address and sizes
	// ************************************************************
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [5:0] FLAGS_RST = 6'h00;
	localparam logic [11:0] PC_RST = 12'h000;
	localparam logic [6:0] PCL_ADDR = 7'h06;
	localparam int unsigned MEM_WORDS = 128;
	localparam int unsigned STACK_DEPTH = 8;

	typedef enum logic [4:0] {
		OP_SUM = 5'h00, OP_SUM_C = 5'h01, OP_MINUS = 5'h02, OP_MINUS_B = 5'h03,
		OP_BCD_ADJ = 5'h04, OP_CONJ = 5'h05, OP_DISJ = 5'h06, OP_EXCL = 5'h07,
		OP_INVERT = 5'h08, OP_STEP_UP = 5'h09, OP_STEP_DOWN = 5'h0a, OP_ROT_R = 5'h0b,
		OP_ROT_L = 5'h0c, OP_ROTC_R = 5'h0d, OP_ROTC_L = 5'h0e, OP_LOAD_W = 5'h0f,
		OP_STORE_M = 5'h10, OP_BIT_HIGH = 5'h11, OP_BIT_LOW = 5'h12, OP_SKIP_Z = 5'h13,
		OP_SKIP_NZ = 5'h14, OP_SKIP_BZ = 5'h15, OP_SKIP_BNZ = 5'h16, OP_SKIP_UPZ = 5'h17,
		OP_SKIP_DNZ = 5'h18, OP_JUMP = 5'h19, OP_CALL = 5'h1a, OP_EXIT = 5'h1b,
		OP_IEXIT = 5'h1c, OP_TABLE = 5'h1d, OP_NOTHING = 5'h1e
	} mbt_op_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_EXTRA = 3'b100
	} mbt_state_t;

endpackage : mbt_pkg

// *** logic/mbt_phase.sv ***
`timescale 1ns/1ns
`default_nettype none
module mbt_phase (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic ce,
	// Control
	input wire logic clear,
	// Timing
	output logic [1:0] phase_q,
	output logic cycle_end
);
	logic [1:0] phase_d;

	assign phase_d = clear ? 2'h0 : 2'(phase_q + 2'h1);
	assign cycle_end = ce & ~clear & (phase_q == mbt_pkg::PHASE_LAST);

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			phase_q <= 2'h0;
		else if (ce)
			phase_q <= phase_d;
	end
endmodule : mbt_phase
`default_nettype wire

// *** logic/mbt_alu.sv ***
`timescale 1ns/1ns
`default_nettype none
module mbt_alu (
	// Operation
	input wire mbt_pkg::mbt_op_t op,
	input wire logic imm_sel,
	input wire logic to_mem,
	input wire logic [2:0] bit_idx,
	// Operands
	input wire logic [7:0] work,
	input wire logic [7:0] mem_val,
	input wire logic [7:0] imm,
	input wire logic [5:0] flags,
	// Results
	output logic [7:0] result,
	output logic [5:0] new_flags,
	output logic wr_work,
	output logic wr_mem,
	output logic skip
);
	logic is_sub;
	logic cin;
	logic [7:0] opnd;
	logic [7:0] b_eff;
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [7:0] sum8;
	logic [7:0] up;
	logic [7:0] down;
	logic [7:0] bit_mask;
	logic [8:0] bcd_lo;
	logic [8:0] bcd;
	logic dst_mem;

	assign opnd = imm_sel ? imm : mem_val;
	assign is_sub = (op == mbt_pkg::OP_MINUS) | (op == mbt_pkg::OP_MINUS_B);
	assign cin = (op == mbt_pkg::OP_SUM_C) | (op == mbt_pkg::OP_MINUS_B) ?
		flags[mbt_pkg::FLG_C] : is_sub;
	assign b_eff = is_sub ? ~opnd : opnd;
	assign sum9 = {1'b0, work} + {1'b0, b_eff} + {8'h00, cin};
	assign sum5 = {1'b0, work[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
	assign sum8 = {1'b0, work[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
	assign up = 8'(mem_val + 8'h01);
	assign down = 8'(mem_val - 8'h01);
	assign bit_mask = 8'(8'h01 << bit_idx);
	assign bcd_lo = (work[3:0] > 4'h9 || flags[mbt_pkg::FLG_HC]) ?
		9'({1'b0, work} + 9'h006) : {1'b0, work};
	assign bcd = (bcd_lo[7:4] > 4'h9 || bcd_lo[8] || flags[mbt_pkg::FLG_C]) ?
		9'(bcd_lo + 9'h060) : bcd_lo;
	assign dst_mem = to_mem & ~imm_sel;

	always_comb
	begin
		result = mem_val;
		new_flags = flags;
		wr_work = 1'b0;
		wr_mem = 1'b0;
		skip = 1'b0;
		case (op)
			mbt_pkg::OP_SUM, mbt_pkg::OP_SUM_C, mbt_pkg::OP_MINUS, mbt_pkg::OP_MINUS_B:
			begin
				result = sum9[7:0];
				wr_work = ~dst_mem;
				wr_mem = dst_mem;
				new_flags[mbt_pkg::FLG_C] = sum9[8];
				new_flags[mbt_pkg::FLG_HC] = sum5[4];
				new_flags[mbt_pkg::FLG_Z] = (sum9[7:0] == 8'h00);
				new_flags[mbt_pkg::FLG_OVF] = sum8[7] ^ sum9[8];
				new_flags[mbt_pkg::FLG_SGN] = sum9[7] ^ sum8[7] ^ sum9[8];
				if (is_sub)
					new_flags[mbt_pkg::FLG_CHZ] = (sum9[7:0] == 8'h00) &
						((op == mbt_pkg::OP_MINUS) | flags[mbt_pkg::FLG_CHZ]);
			end
			mbt_pkg::OP_BCD_ADJ:
			begin
				result = bcd[7:0];
				wr_mem = 1'b1;
				new_flags[mbt_pkg::FLG_C] = bcd[8] | flags[mbt_pkg::FLG_C];
			end
			mbt_pkg::OP_CONJ, mbt_pkg::OP_DISJ, mbt_pkg::OP_EXCL:
			begin
				result = (op == mbt_pkg::OP_CONJ) ? (work & opnd) :
					(op == mbt_pkg::OP_DISJ) ? (work | opnd) : (work ^ opnd);
				wr_work = ~dst_mem;
				wr_mem = dst_mem;
				new_flags[mbt_pkg::FLG_Z] = (result == 8'h00);
			end
			mbt_pkg::OP_INVERT, mbt_pkg::OP_STEP_UP, mbt_pkg::OP_STEP_DOWN:
			begin
				result = (op == mbt_pkg::OP_INVERT) ? ~mem_val :
					(op == mbt_pkg::OP_STEP_UP) ? up : down;
				wr_work = ~to_mem;
				wr_mem = to_mem;
				new_flags[mbt_pkg::FLG_Z] = (result == 8'h00);
			end
			mbt_pkg::OP_ROT_R, mbt_pkg::OP_ROT_L:
			begin
				result = (op == mbt_pkg::OP_ROT_R) ? {mem_val[0], mem_val[7:1]} :
					{mem_val[6:0], mem_val[7]};
				wr_work = ~to_mem;
				wr_mem = to_mem;
			end
			mbt_pkg::OP_ROTC_R, mbt_pkg::OP_ROTC_L:
			begin
				result = (op == mbt_pkg::OP_ROTC_R) ?
					{flags[mbt_pkg::FLG_C], mem_val[7:1]} :
					{mem_val[6:0], flags[mbt_pkg::FLG_C]};
				new_flags[mbt_pkg::FLG_C] = (op == mbt_pkg::OP_ROTC_R) ? mem_val[0] : mem_val[7];
				wr_work = ~to_mem;
				wr_mem = to_mem;
			end
			mbt_pkg::OP_LOAD_W:
			begin
				result = opnd;
				wr_work = 1'b1;
			end
			mbt_pkg::OP_STORE_M:
			begin
				result = work;
				wr_mem = 1'b1;
			end
			mbt_pkg::OP_BIT_HIGH, mbt_pkg::OP_BIT_LOW:
			begin
				result = (op == mbt_pkg::OP_BIT_HIGH) ? (mem_val | bit_mask) :
					(mem_val & ~bit_mask);
				wr_mem = 1'b1;
			end
			mbt_pkg::OP_SKIP_Z, mbt_pkg::OP_SKIP_NZ:
			begin
				skip = (mem_val == 8'h00) ^ (op == mbt_pkg::OP_SKIP_NZ);
				wr_work = ~to_mem & (op == mbt_pkg::OP_SKIP_Z);
			end
			mbt_pkg::OP_SKIP_BZ, mbt_pkg::OP_SKIP_BNZ:
				skip = ((mem_val & bit_mask) == 8'h00) ^ (op == mbt_pkg::OP_SKIP_BNZ);
			mbt_pkg::OP_SKIP_UPZ, mbt_pkg::OP_SKIP_DNZ:
			begin
				result = (op == mbt_pkg::OP_SKIP_UPZ) ? up : down;
				skip = (result == 8'h00);
				wr_work = ~to_mem;
				wr_mem = to_mem;
			end
			mbt_pkg::OP_EXIT, mbt_pkg::OP_IEXIT:
			begin
				result = imm;
				wr_work = imm_sel;
			end
			mbt_pkg::OP_TABLE:
			begin
				result = imm;
				wr_mem = 1'b1;
			end
			default:
				result = mem_val;
		endcase
	end
endmodule : mbt_alu
`default_nettype wire

// *** logic/mbt_core.sv ***
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module mbt_core (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic ce,
	// Avalon-MM slave
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Core state
	output logic [7:0] working_register,
	output logic [5:0] status_flags,
	output logic [11:0] program_counter,
	output logic [1:0] clock_phase,
	output logic instr_busy
);
	// ************************************************************
	// State
	// ************************************************************
	mbt_pkg::mbt_state_t state_q;
	mbt_pkg::mbt_state_t state_d;
	logic [31:0] instr_q;
	logic [7:0] work_q;
	logic [5:0] flags_q;
	logic [11:0] pc_q;
	logic [11:0] pc_d;
	logic [2:0] sp_q;
	logic [11:0] stack_q [mbt_pkg::STACK_DEPTH];
	logic [7:0] mem_q [mbt_pkg::MEM_WORDS];
	logic [1:0] extra_q;
	logic [1:0] last_cyc_q;
	logic [31:0] total_cyc_q;
	logic skip_q;
	logic rd_ack_q;
	logic [31:0] rdata_q;

	// ************************************************************
	// Instruction decode
	// ************************************************************
	mbt_pkg::mbt_op_t op;
	logic imm_sel;
	logic to_mem;
	logic [2:0] bit_idx;
	logic [6:0] daddr;
	logic [11:0] target;
	logic [7:0] imm;
	logic [7:0] mem_val;
	logic pcl_sel;

	assign op = mbt_pkg::mbt_op_t'(instr_q[mbt_pkg::F_OP_LSB +: 5]);
	assign imm_sel = instr_q[mbt_pkg::F_IMM_SEL];
	assign to_mem = instr_q[mbt_pkg::F_TO_MEM];
	assign bit_idx = instr_q[mbt_pkg::F_BIT_LSB +: 3];
	assign daddr = instr_q[mbt_pkg::F_ADDR_LSB +: 7];
	assign target = instr_q[mbt_pkg::F_TARGET_LSB +: 12];
	assign imm = instr_q[mbt_pkg::F_IMM_LSB +: 8];
	assign pcl_sel = (daddr == mbt_pkg::PCL_ADDR);
	assign mem_val = pcl_sel ? pc_q[7:0] : mem_q[daddr];

	// ************************************************************
	// Arithmetic and cycle timing
	// ************************************************************
	logic [7:0] result;
	logic [5:0] new_flags;
	logic wr_work;
	logic wr_mem;
	logic skip;
	logic cycle_end;
	logic start;

	mbt_alu u_alu (
		.op(op),
		.imm_sel(imm_sel),
		.to_mem(to_mem),
		.bit_idx(bit_idx),
		.work(work_q),
		.mem_val(mem_val),
		.imm(imm),
		.flags(flags_q),
		.result(result),
		.new_flags(new_flags),
		.wr_work(wr_work),
		.wr_mem(wr_mem),
		.skip(skip)
	);

	mbt_phase u_phase (
		.mclk(mclk),
		.arst_n(arst_n),
		.ce(ce),
		.clear(start),
		.phase_q(clock_phase),
		.cycle_end(cycle_end)
	);

	// ************************************************************
	// Bus decode
	// ************************************************************
	logic busy;
	logic wr_ok;
	logic mem_win;
	logic [6:0] win_addr;
	logic sel_instr;
	logic sel_work;
	logic sel_status;
	logic sel_pc;
	logic [31:0] rd_mux;

	assign busy = (state_q != mbt_pkg::ST_IDLE);
	assign avs_waitrequest = ~ce | (avs_read & ~rd_ack_q) | (avs_write & busy);
	assign wr_ok = ce & avs_write & ~busy;
	assign mem_win = avs_address[mbt_pkg::MEM_WIN_BIT];
	assign win_addr = avs_address[8:2];
	assign sel_instr = ~mem_win & (avs_address == mbt_pkg::OFS_INSTR);
	assign sel_work = ~mem_win & (avs_address == mbt_pkg::OFS_WORK);
	assign sel_status = ~mem_win & (avs_address == mbt_pkg::OFS_STATUS);
	assign sel_pc = ~mem_win & (avs_address == mbt_pkg::OFS_PC);
	assign start = wr_ok & sel_instr;
	assign rd_mux = mem_win ? {24'h000000, mem_q[win_addr]} :
		sel_instr ? instr_q :
		sel_work ? {24'h000000, work_q} :
		sel_status ? {22'h0, skip_q, busy, 2'h0, flags_q} :
		sel_pc ? {20'h00000, pc_q} :
		(avs_address == mbt_pkg::OFS_CYC_LAST) ? {30'h0, last_cyc_q} :
		(avs_address == mbt_pkg::OFS_CYC_TOTAL) ? total_cyc_q : 32'h00000000;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				m[i*8 +: 8] = nw[i*8 +: 8];
		return m;
	endfunction : merge

	// ************************************************************
	// Commit of the first instruction cycle
	// ************************************************************
	logic commit;
	logic base_two;
	logic pcl_hit;
	logic skip_eff;
	logic [1:0] extra;
	logic [11:0] pc_next;
	logic [11:0] pc_skip;
	logic [2:0] sp_prev;
	logic [31:0] pc_wr;
	logic [31:0] work_wr;
	logic [31:0] flags_wr;

	assign commit = cycle_end & (state_q == mbt_pkg::ST_EXEC);
	assign base_two = (op == mbt_pkg::OP_JUMP) | (op == mbt_pkg::OP_CALL) |
		(op == mbt_pkg::OP_EXIT) | (op == mbt_pkg::OP_IEXIT) | (op == mbt_pkg::OP_TABLE);
	assign pcl_hit = wr_mem & pcl_sel;
	assign skip_eff = skip & ~pcl_hit;
	assign extra = 2'({1'b0, base_two} + {1'b0, pcl_hit | skip_eff});
	assign pc_next = 12'(pc_q + 12'h001);
	assign pc_skip = 12'(pc_q + 12'h002);
	assign sp_prev = 3'(sp_q - 3'h1);
	assign pc_wr = merge({20'h00000, pc_q}, avs_writedata, avs_byteenable);
	assign work_wr = merge({24'h000000, work_q}, avs_writedata, avs_byteenable);
	assign flags_wr = merge({26'h0, flags_q}, avs_writedata, avs_byteenable);

	always_comb
	begin
		pc_d = pc_next;
		if (pcl_hit)
			pc_d = {pc_q[11:8], result};
		else if ((op == mbt_pkg::OP_JUMP) || (op == mbt_pkg::OP_CALL))
			pc_d = target;
		else if ((op == mbt_pkg::OP_EXIT) || (op == mbt_pkg::OP_IEXIT))
			pc_d = stack_q[sp_prev];
		else if (skip_eff)
			pc_d = pc_skip;
	end

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			mbt_pkg::ST_IDLE:
				if (start)
					state_d = mbt_pkg::ST_EXEC;
			mbt_pkg::ST_EXEC:
				if (cycle_end)
					state_d = (extra == 2'h0) ? mbt_pkg::ST_IDLE : mbt_pkg::ST_EXTRA;
			mbt_pkg::ST_EXTRA:
				if (cycle_end && (extra_q == 2'h1))
					state_d = mbt_pkg::ST_IDLE;
			default:
				state_d = mbt_pkg::ST_IDLE;
		endcase
	end

	// ************************************************************
	// Sequencer and registers
	// ************************************************************
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= mbt_pkg::ST_IDLE;
			extra_q <= 2'h0;
			skip_q <= 1'b0;
		end
		else if (ce)
		begin
			state_q <= state_d;
			if (commit)
			begin
				extra_q <= extra;
				skip_q <= skip_eff;
			end
			else if (cycle_end)
				extra_q <= 2'(extra_q - 2'h1);
		end
	end

	// ************************************************************
	// Cycle statistics
	// ************************************************************
	logic count_cycle;

	// Phase runs free while idle; only busy cycles are counted
	assign count_cycle = cycle_end & busy;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			last_cyc_q <= 2'h0;
			total_cyc_q <= 32'h00000000;
		end
		else if (ce)
		begin
			if (commit)
				last_cyc_q <= 2'(extra + 2'h1);
			if (count_cycle)
				total_cyc_q <= 32'(total_cyc_q + 32'h00000001);
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			instr_q <= 32'h00000000;
			work_q <= mbt_pkg::WORK_RST;
			flags_q <= mbt_pkg::FLAGS_RST;
			pc_q <= mbt_pkg::PC_RST;
		end
		else if (ce)
		begin
			if (start)
				instr_q <= avs_writedata;
			if (commit)
			begin
				pc_q <= pc_d;
				flags_q <= new_flags;
				if (wr_work)
					work_q <= result;
			end
			else if (wr_ok && sel_work)
				work_q <= work_wr[7:0];
			else if (wr_ok && sel_status)
				flags_q <= flags_wr[5:0];
			else if (wr_ok && sel_pc)
				pc_q <= pc_wr[11:0];
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			sp_q <= 3'h0;
		else if (ce && commit)
		begin
			if (op == mbt_pkg::OP_CALL)
				sp_q <= 3'(sp_q + 3'h1);
			else if ((op == mbt_pkg::OP_EXIT) || (op == mbt_pkg::OP_IEXIT))
				sp_q <= sp_prev;
		end
	end

	// Storage arrays hold data only, no reset
	always_ff @(posedge mclk)
	begin
		if (ce)
		begin
			if (commit && (op == mbt_pkg::OP_CALL))
				stack_q[sp_q] <= pc_next;
			if (commit && wr_mem && !pcl_sel)
				mem_q[daddr] <= result;
			else if (wr_ok && mem_win && avs_byteenable[0])
				mem_q[win_addr] <= avs_writedata[7:0];
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end
		else if (ce)
		begin
			rd_ack_q <= avs_read & ~rd_ack_q;
			if (avs_read && !rd_ack_q)
				rdata_q <= rd_mux;
		end
	end

	assign avs_readdata = rdata_q;
	assign working_register = work_q;
	assign status_flags = flags_q;
	assign program_counter = pc_q;
	assign instr_busy = busy;
endmodule : mbt_core
`default_nettype wire

// *** testbench/mbt_core_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module mbt_core_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic ce,
	// Bus handshake
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// Core state
	input wire logic [7:0] working_register,
	input wire logic [5:0] status_flags,
	input wire logic [11:0] program_counter,
	input wire logic [1:0] clock_phase,
	input wire logic instr_busy
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	// ********
	// Sequences
	// ********
	sequence s_icycle;
		instr_busy && clock_phase == 2'h0 ##1 instr_busy && clock_phase == 2'h1
		##1 instr_busy && clock_phase == 2'h2 ##1 instr_busy && clock_phase == 2'h3;
	endsequence
	sequence s_one_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence

	// ********
	// Assertions
	// ********
	a_cycle_shape: assert property ($rose(instr_busy) |-> s_icycle)
		else $error("instruction cycle not four phases");
	a_busy_bound: assert property ($rose(instr_busy) |-> ##[4:12] !instr_busy)
		else $error("instruction longer than three cycles");
	a_phase_end: assert property ($fell(instr_busy) |-> $past(clock_phase) == 2'h3)
		else $error("instruction ended mid cycle");
	a_phase_step: assert property (instr_busy && ce && clock_phase != 2'h3 |=>
		clock_phase == $past(clock_phase) + 2'h1)
		else $error("phase did not advance by one");
	a_hold_mid: assert property (instr_busy && clock_phase != 2'h3 |=>
		$stable(working_register) && $stable(status_flags))
		else $error("result committed before phase three");
	a_idle_hold: assert property (!instr_busy && !avs_write |=>
		$stable(status_flags) && $stable(program_counter))
		else $error("state changed while idle");
	a_write_nowait: assert property (avs_write && ce && !instr_busy |-> !avs_waitrequest)
		else $error("idle write was stalled");
	a_busy_stall: assert property (avs_write && instr_busy |-> avs_waitrequest)
		else $error("write accepted while busy");
	a_read_wait: assert property ($rose(avs_read) && ce |-> s_one_wait)
		else $error("read not answered after one wait");
endmodule : mbt_core_chk

bind mbt_core mbt_core_chk chk_u (.mclk, .arst_n, .ce, .avs_read, .avs_write, .avs_waitrequest,
	.working_register, .status_flags, .program_counter, .clock_phase, .instr_busy);
`default_nettype wire

// *** testbench/test_mcu_base_instruction_timing_alu.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("FAIL %s expected %h seen %h", n, e, g); end end
module test_mcu_base_instruction_timing_alu;
	typedef struct {
		logic [4:0] op;
		logic [1:0] md;
		logic [2:0] b;
		logic [7:0] x, w0, m0;
		logic [5:0] f0;
		logic [7:0] w1, m1;
		logic [5:0] f1;
		logic [3:0] tm;
	} mbt_row_t;

	logic mclk, arst_n, ce, avs_read, avs_write, avs_waitrequest, instr_busy;
	logic [8:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, d;
	logic [3:0] avs_byteenable;
	logic [7:0] working_register;
	logic [5:0] status_flags;
	logic [11:0] program_counter, pc0;
	logic [1:0] clock_phase;
	int error_cnt, checked, cyc, n;

	// Op, mode, bit, imm, work, mem, flags in; work, mem, flags out; cycles and pc step
	mbt_row_t rows [27] = '{
		'{5'h00,2'h0,3'h0,8'h00,8'hff,8'h01,6'h20,8'h00,8'h01,6'h27,4'h5},
		'{5'h01,2'h2,3'h0,8'h00,8'h7f,8'h00,6'h01,8'h7f,8'h80,6'h0a,4'h5},
		'{5'h02,2'h1,3'h0,8'h20,8'h10,8'h33,6'h00,8'hf0,8'h33,6'h12,4'h5},
		'{5'h03,2'h2,3'h0,8'h00,8'h05,8'h05,6'h20,8'h05,8'hff,6'h10,4'h5},
		'{5'h03,2'h0,3'h0,8'h00,8'h05,8'h05,6'h21,8'h00,8'h05,6'h27,4'h5},
		'{5'h04,2'h2,3'h0,8'h00,8'ha0,8'h11,6'h04,8'ha0,8'h00,6'h05,4'h5},
		'{5'h05,2'h1,3'h0,8'h0f,8'hf0,8'h11,6'h3b,8'h00,8'h11,6'h3f,4'h5},
		'{5'h06,2'h2,3'h0,8'h00,8'h0f,8'hf0,6'h3f,8'h0f,8'hff,6'h3b,4'h5},
		'{5'h07,2'h0,3'h0,8'h00,8'h5a,8'h5a,6'h00,8'h00,8'h5a,6'h04,4'h5},
		'{5'h08,2'h2,3'h0,8'h00,8'h11,8'hff,6'h00,8'h11,8'h00,6'h04,4'h5},
		'{5'h09,2'h0,3'h0,8'h00,8'h11,8'hff,6'h01,8'h00,8'hff,6'h05,4'h5},
		'{5'h0a,2'h2,3'h0,8'h00,8'h11,8'h00,6'h04,8'h11,8'hff,6'h00,4'h5},
		'{5'h0b,2'h2,3'h0,8'h00,8'h11,8'h01,6'h3f,8'h11,8'h80,6'h3f,4'h5},
		'{5'h0c,2'h0,3'h0,8'h00,8'h11,8'h80,6'h00,8'h01,8'h80,6'h00,4'h5},
		'{5'h0d,2'h2,3'h0,8'h00,8'h11,8'h01,6'h04,8'h11,8'h00,6'h05,4'h5},
		'{5'h0e,2'h0,3'h0,8'h00,8'h11,8'h40,6'h3f,8'h81,8'h40,6'h3e,4'h5},
		'{5'h11,2'h2,3'h7,8'h00,8'h11,8'h00,6'h00,8'h11,8'h80,6'h00,4'h5},
		'{5'h12,2'h2,3'h0,8'h00,8'h11,8'hff,6'h3f,8'h11,8'hfe,6'h3f,4'h5},
		'{5'h13,2'h2,3'h0,8'h00,8'h11,8'h00,6'h00,8'h11,8'h00,6'h00,4'ha},
		'{5'h14,2'h2,3'h0,8'h00,8'h11,8'h00,6'h00,8'h11,8'h00,6'h00,4'h5},
		'{5'h16,2'h2,3'h3,8'h00,8'h11,8'h08,6'h00,8'h11,8'h08,6'h00,4'ha},
		'{5'h17,2'h2,3'h0,8'h00,8'h11,8'hff,6'h00,8'h11,8'h00,6'h00,4'ha},
		'{5'h18,2'h2,3'h0,8'h00,8'h11,8'h02,6'h00,8'h11,8'h01,6'h00,4'h5},
		'{5'h1d,2'h2,3'h0,8'h5c,8'h11,8'h00,6'h00,8'h11,8'h5c,6'h00,4'h9},
		'{5'h0f,2'h1,3'h0,8'h3c,8'h11,8'h00,6'h3f,8'h3c,8'h00,6'h3f,4'h5},
		'{5'h15,2'h2,3'h0,8'h00,8'h11,8'hfe,6'h00,8'h11,8'hfe,6'h00,4'ha},
		'{5'h13,2'h0,3'h0,8'h00,8'h11,8'h00,6'h00,8'h00,8'h00,6'h00,4'ha}
	};

	mbt_core dut_u (.mclk, .arst_n, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .working_register, .status_flags,
		.program_counter, .clock_phase, .instr_busy);

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			finish_test();
		end
	end

	// ********
	// Tasks
	// ********
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] wd);
		logic w;
		avs_read <= ~wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= wd;
		do
		begin
			@(posedge mclk);
			w = avs_waitrequest;
			d = avs_readdata;
		end
		while (w !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask : bus

	// First busy clock passes inside the bus handshake
	task automatic exec(input logic [31:0] iw);
		bus(1'b1, 9'h000, iw);
		n = 1;
		@(negedge mclk);
		while (instr_busy === 1'b1)
		begin
			n++;
			@(negedge mclk);
		end
		@(posedge mclk);
	endtask : exec

	// ********
	// Sequence
	// ********
	initial
	begin
		arst_n = 1'b0;
		ce = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 9'h000;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		repeat (20) @(posedge mclk);
		`CHK("work reset", mbt_pkg::WORK_RST, working_register)
		`CHK("flags reset", mbt_pkg::FLAGS_RST, status_flags)
		`CHK("pc reset", mbt_pkg::PC_RST, program_counter)
		`CHK("busy reset", 1'b0, instr_busy)
		arst_n <= 1'b1;
		@(posedge mclk);
		bus(1'b0, 9'h0fc, 32'h0);
		`CHK("unmapped read", 32'h0, d)
		bus(1'b0, 9'h014, 32'h0);
		`CHK("idle cycles", 32'h0, d)
		foreach (rows[i])
		begin
			bus(1'b1, 9'h004, {24'h0, rows[i].w0});
			bus(1'b1, 9'h008, {26'h0, rows[i].f0});
			bus(1'b1, 9'h140, {24'h0, rows[i].m0});
			pc0 = program_counter;
			exec({rows[i].x, 7'h0, 7'h50, rows[i].b, rows[i].md, rows[i].op});
			`CHK("clocks", 4 * rows[i].tm[3:2], n)
			`CHK("pc step", {10'h0, rows[i].tm[1:0]}, 12'(program_counter - pc0))
			`CHK("work", rows[i].w1, working_register)
			`CHK("flags", rows[i].f1, status_flags)
			bus(1'b0, 9'h140, 32'h0);
			`CHK("mem", {24'h0, rows[i].m1}, d)
			bus(1'b0, 9'h010, 32'h0);
			`CHK("last cycles", {30'h0, rows[i].tm[3:2]}, d)
		end
		bus(1'b1, 9'h00c, 32'h10);
		exec({4'h0, 12'h345, 11'h0, 5'h19});
		`CHK("jump pc", 12'h345, program_counter)
		`CHK("jump clocks", 8, n)
		exec({4'h0, 12'h200, 11'h0, 5'h1a});
		`CHK("call pc", 12'h200, program_counter)
		`CHK("call clocks", 8, n)
		exec({4'h0, 12'h300, 11'h0, 5'h19});
		exec({27'h0, 5'h1b});
		`CHK("return pc", 12'h346, program_counter)
		bus(1'b1, 9'h004, 32'h77);
		exec({8'h0, 7'h0, 7'h06, 3'h0, 2'h2, 5'h10});
		`CHK("low byte pc", 12'h377, program_counter)
		`CHK("low byte clocks", 8, n)
		exec({8'h42, 7'h0, 7'h06, 3'h0, 2'h2, 5'h1d});
		`CHK("table pc", 12'h342, program_counter)
		`CHK("table pc clocks", 12, n)
		ce <= 1'b0;
		@(posedge mclk);
		pc0 = {10'h0, clock_phase};
		repeat (3) @(posedge mclk);
		`CHK("frozen phase", pc0[1:0], clock_phase)
		`CHK("frozen wait", 1'b1, avs_waitrequest)
		ce <= 1'b1;
		bus(1'b1, 9'h000, {27'h0, 5'h1e});
		bus(1'b1, 9'h004, 32'h99);
		`CHK("stalled write", 8'h99, working_register)
		`CHK("stall end", 1'b0, instr_busy)
		bus(1'b1, 9'h000, {27'h0, 5'h1e});
		arst_n <= 1'b0;
		@(negedge mclk);
		`CHK("mid reset busy", 1'b0, instr_busy)
		`CHK("mid reset pc", mbt_pkg::PC_RST, program_counter)
		@(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		exec({27'h0, 5'h1e});
		`CHK("after reset clocks", 4, n)
		`CHK("after reset pc", 12'h001, program_counter)
		finish_test();
	end
endmodule : test_mcu_base_instruction_timing_alu
`default_nettype wire
